// file: logic/tpm_meter.sv
// Ingress policer: token bucket meter, colour actions, Wishbone registers
//
// Function
// RULE_01: Simple bucket counts one byte per token, bursts limited to bucket depth.
// RULE_02: Single-rate mode colours with committed rate, committed and excess depths.
// RULE_03: Two-rate mode colours with independent committed and peak rates.
// RULE_04: Software keeps committed depth at or below the second depth.
// RULE_05: Committed depth caps the first bucket in every mode.
// RULE_06: Single-rate: excess depth caps second bucket, filled at committed rate.
// RULE_07: Two-rate: peak depth caps the second bucket.
// RULE_08: Two-rate: second bucket gains peak-rate byte tokens each second.
// RULE_09: Software should set peak rate at or above committed rate.
// RULE_10: Traffic within the committed rate is green.
// RULE_11: Green packets pass unchanged or get the green DSCP mark.
// RULE_12: Yellow packets pass, drop, or get a 0..63 DSCP mark.
// RULE_13: Remarked yellow packets drop under congestion.
// RULE_14: Yellow only exists in three-colour modes.
// RULE_15: Red packets drop, or get remarked and drop under congestion.
// RULE_16: Disabled policer neither meters nor acts on traffic.
// RULE_17: Admitted length leaves the deciding buckets, never below zero.
// RULE_18: Buckets full at reset and enable; refill saturates at depth.
`timescale 1ns/100ps
`include "tpm_defines.svh"
module tpm_meter
	import tpm_pkg::*;
#(
	parameter int LEN_W = 16,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [LEN_W-1:0] in_len,
	input wire logic [5:0] in_dscp,
	input wire logic in_member,
	input wire logic congested,
	output logic out_valid,
	input wire logic out_ready,
	output logic [LEN_W-1:0] out_len,
	output logic [5:0] out_dscp,
	output logic [1:0] out_colour
);
	localparam int FW = LEN_W + 8;

	// ----------------------------------------
	// Functions
	// ----------------------------------------

	// Byte-lane merge of a write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Rate accumulator: one token each time the sum reaches the clock rate
	function automatic logic [32:0] acc_step(input logic [31:0] frac, input logic [31:0] rate);
		logic [32:0] s;
		s = {1'b0, frac} + {1'b0, rate};
		if (s >= 33'(`TPM_CLK_HZ)) begin
			return {1'b1, 32'(s - 33'(`TPM_CLK_HZ))};
		end
		return {1'b0, s[31:0]};
	endfunction

	// Subtract clamped at zero, add refill, saturate at depth
	function automatic logic [31:0] bkt_next(input logic [31:0] b, input logic [31:0] sub,
		input logic add, input logic [31:0] cap);
		logic [32:0] t;
		t = (sub > b) ? 33'h0_0000_0000 : {1'b0, b - sub};
		t = t + 33'(add);
		return (t > {1'b0, cap}) ? cap : t[31:0];
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [31:0] ctrl;
	logic [31:0] cir;
	logic [31:0] pir;
	logic [31:0] cbs;
	logic [31:0] xbs;
	logic [31:0] mark;
	logic [31:0] lvl1;
	logic [31:0] lvl2;
	logic [31:0] frac_c;
	logic [31:0] frac_p;
	logic cong_m;
	logic cong_s;
	logic st_valid;
	logic st_drop;
	logic [LEN_W-1:0] st_len;
	logic [5:0] st_dscp;
	tpm_colour_t st_colour;

	// ----------------------------------------
	// Control field decode
	// ----------------------------------------
	wire enable = ctrl[`TPM_CTRL_EN];
	wire [1:0] mode_raw = ctrl[`TPM_CTRL_MODE +: 2];
	wire is_sr = mode_raw == 2'h1;
	wire is_tr = mode_raw == 2'h2;
	wire tpm_mode_t mode = is_tr ? tpm_trtcm : (is_sr ? tpm_srtcm : tpm_stb);
	wire g_mark = ctrl[`TPM_CTRL_GMARK];
	wire [1:0] y_act = ctrl[`TPM_CTRL_YACT +: 2];
	wire r_mark = ctrl[`TPM_CTRL_RMARK];
	wire [5:0] dscp_g = mark[`TPM_MARK_G +: 6];
	wire [5:0] dscp_y = mark[`TPM_MARK_Y +: 6];
	wire [5:0] dscp_r = mark[`TPM_MARK_R +: 6];

	// ----------------------------------------
	// Wishbone slave
	// ----------------------------------------
	wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wb_wr = wb_req && wb_we_i;
	wire [5:0] widx = wb_adr_i[7:2];
	wire [31:0] rd_mux =
		(widx == `TPM_OFF_CTRL) ? ctrl :
		(widx == `TPM_OFF_CIR) ? cir :
		(widx == `TPM_OFF_PIR) ? pir :
		(widx == `TPM_OFF_CBS) ? cbs :
		(widx == `TPM_OFF_XBS) ? xbs :
		(widx == `TPM_OFF_MARK) ? mark :
		(widx == `TPM_OFF_LVL1) ? lvl1 :
		(widx == `TPM_OFF_LVL2) ? lvl2 : 32'h0000_0000;

	// Ack one cycle after the request, unmapped reads give zero
	always_ff @(posedge clock) begin
		if (!resetn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req ? rd_mux : 32'h0000_0000;
		end
	end

	// Writable registers, written as the ack is raised
	always_ff @(posedge clock) begin
		if (!resetn) begin
			ctrl <= `TPM_RST_CTRL;
			cir <= `TPM_RST_CIR;
			pir <= `TPM_RST_PIR;
			cbs <= `TPM_RST_CBS;
			xbs <= `TPM_RST_XBS;
			mark <= `TPM_RST_MARK;
		end else if (wb_wr) begin
			case (widx)
				`TPM_OFF_CTRL: ctrl <= merge(ctrl, wb_dat_i, wb_sel_i) & 32'h0000_007f;
				`TPM_OFF_CIR: cir <= merge(cir, wb_dat_i, wb_sel_i);
				`TPM_OFF_PIR: pir <= merge(pir, wb_dat_i, wb_sel_i);
				`TPM_OFF_CBS: cbs <= merge(cbs, wb_dat_i, wb_sel_i);
				`TPM_OFF_XBS: xbs <= merge(xbs, wb_dat_i, wb_sel_i);
				`TPM_OFF_MARK: mark <= merge(mark, wb_dat_i, wb_sel_i) & 32'h003f_3f3f;
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Congestion pin synchroniser
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!resetn) begin
			cong_m <= 1'b0;
			cong_s <= 1'b0;
		end else begin
			cong_m <= congested;
			cong_s <= cong_m;
		end
	end

	// ----------------------------------------
	// Colour decision
	// ----------------------------------------
	wire take = in_valid && in_ready;
	wire metered = enable && in_member; // RULE_16
	wire [31:0] len32 = 32'(in_len);
	wire fit1 = len32 <= lvl1; // RULE_01
	wire fit2 = len32 <= lvl2;
	wire tpm_colour_t colour =
		!metered ? tpm_green :
		is_tr ? (!fit2 ? tpm_red : (!fit1 ? tpm_yellow : tpm_green)) : // RULE_03
		is_sr ? (fit1 ? tpm_green : (fit2 ? tpm_yellow : tpm_red)) : // RULE_02
		(fit1 ? tpm_green : tpm_red); // RULE_14

	// Bytes taken from each bucket by the admitted packet
	wire use1 = take && metered && colour == tpm_green;
	wire use2 = take && metered && ((is_sr && colour == tpm_yellow) ||
		(is_tr && colour != tpm_red));
	wire [31:0] sub1 = use1 ? len32 : 32'h0000_0000; // RULE_17
	wire [31:0] sub2 = use2 ? len32 : 32'h0000_0000; // RULE_17

	// ----------------------------------------
	// Colour actions
	// ----------------------------------------
	wire y_mark = y_act == tpm_ymark;
	wire [5:0] next_dscp =
		(colour == tpm_green) ? (g_mark ? dscp_g : in_dscp) : // RULE_11
		(colour == tpm_yellow) ? (y_mark ? dscp_y : in_dscp) : // RULE_12
		(r_mark ? dscp_r : in_dscp); // RULE_15
	wire next_drop =
		(colour == tpm_yellow) ? (y_act == tpm_ydrop || (y_mark && cong_s)) : // RULE_13
		(colour == tpm_red) ? (!r_mark || cong_s) : 1'b0; // RULE_15

	// ----------------------------------------
	// Refill
	// ----------------------------------------
	wire [32:0] step_c = acc_step(frac_c, cir);
	wire [32:0] step_p = acc_step(frac_p, pir);
	wire tok_c = step_c[32];
	wire tok_p = step_p[32];
	wire add1 = tok_c; // RULE_05
	wire add2 = is_tr ? tok_p : (is_sr && tok_c && lvl1 >= cbs); // RULE_06 RULE_08

	// Rate accumulators, one second of clocks per rate worth of tokens
	always_ff @(posedge clock) begin
		if (!resetn || !enable) begin
			frac_c <= 32'h0000_0000;
			frac_p <= 32'h0000_0000;
		end else begin
			frac_c <= step_c[31:0];
			frac_p <= step_p[31:0];
		end
	end

	// Bucket levels, held full while disabled
	always_ff @(posedge clock) begin
		if (!resetn) begin
			lvl1 <= `TPM_RST_CBS;
			lvl2 <= `TPM_RST_XBS;
		end else if (!enable) begin
			lvl1 <= cbs; // RULE_18
			lvl2 <= xbs; // RULE_18
		end else begin
			lvl1 <= bkt_next(lvl1, sub1, add1, cbs); // RULE_05 RULE_18
			lvl2 <= bkt_next(lvl2, sub2, add2, xbs); // RULE_06 RULE_07
		end
	end

	// ----------------------------------------
	// Result stage and output FIFO
	// ----------------------------------------
	logic f_ready;
	logic [FW-1:0] f_data;
	wire st_done = st_valid && (st_drop || f_ready);

	// One packet in flight; dropped packets never reach the FIFO
	always_ff @(posedge clock) begin
		if (!resetn) begin
			st_valid <= 1'b0;
			st_drop <= 1'b0;
			st_len <= '0;
			st_dscp <= 6'h00;
			st_colour <= tpm_green;
			in_ready <= 1'b0;
		end else if (take) begin
			st_valid <= 1'b1;
			st_drop <= metered && next_drop; // RULE_16
			st_len <= in_len;
			st_dscp <= metered ? next_dscp : in_dscp; // RULE_16
			st_colour <= colour; // RULE_10
			in_ready <= 1'b0;
		end else if (st_done || !st_valid) begin
			st_valid <= 1'b0;
			in_ready <= 1'b1;
		end
	end

	tpm_fifo #(
		.WIDTH(FW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.resetn(resetn),
		.in_valid(st_valid && !st_drop),
		.in_ready(f_ready),
		.in_data({st_colour, st_dscp, st_len}),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(f_data)
	);

	assign out_len = f_data[LEN_W-1:0];
	assign out_dscp = f_data[LEN_W +: 6];
	assign out_colour = f_data[LEN_W+6 +: 2];

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	chk_first_cap: assert property (##1 lvl1 <= $past(cbs)) // RULE_05
		else $error("first bucket above committed depth");
	chk_second_cap: assert property (##1 lvl2 <= $past(xbs)) // RULE_07
		else $error("second bucket above its depth");
	chk_stb_colours: assert property (take && mode == tpm_stb |=> st_colour != tpm_yellow) // RULE_14
		else $error("yellow from simple bucket");
	chk_green_fit: assert property (take && metered && fit1 && !is_tr |=> st_colour == tpm_green) // RULE_10
		else $error("fitting packet not green");
	chk_sr_yellow: assert property (take && metered && is_sr && !fit1 && fit2
		|=> st_colour == tpm_yellow) // RULE_02
		else $error("single-rate yellow missed");
	chk_tr_red: assert property (take && metered && is_tr && !fit2 |=> st_colour == tpm_red) // RULE_03
		else $error("two-rate red missed");
	chk_debit: assert property (take && metered && !is_tr && fit1 && !tok_c
		|=> lvl1 == $past(lvl1) - $past(len32)) // RULE_17
		else $error("debit wrong");
	chk_peak_fill: assert property (enable && is_tr && tok_p && !take && lvl2 < xbs && $stable(xbs)
		|=> lvl2 == $past(lvl2) + 32'h0000_0001) // RULE_08
		else $error("peak refill lost");
	chk_yellow_cong: assert property (take && metered && colour == tpm_yellow && y_mark && cong_s
		|=> st_drop) // RULE_13
		else $error("remarked yellow kept under congestion");
	chk_green_mark: assert property (take && metered && colour == tpm_green && g_mark
		|=> st_dscp == $past(dscp_g) && !st_drop) // RULE_11
		else $error("green mark wrong");
	chk_off_pass: assert property (take && !enable
		|=> !st_drop && st_dscp == $past(in_dscp) && st_colour == tpm_green) // RULE_16
		else $error("disabled policer acted");
	chk_enable_full: assert property ($rose(enable) |-> lvl1 == $past(cbs) && lvl2 == $past(xbs)) // RULE_18
		else $error("buckets not full at enable");
	chk_yellow_drop: assert property (take && metered && colour == tpm_yellow && y_act == tpm_ydrop |=> st_drop) // RULE_12
		else $error("yellow drop action ignored");
	chk_red_cong: assert property (take && metered && colour == tpm_red && cong_s |=> st_drop) // RULE_15
		else $error("red packet kept under congestion");

	cov_yellow: cover property (take && colour == tpm_yellow);
	cov_red_drop: cover property (take && colour == tpm_red ##1 st_drop);
	cov_fifo_full: cover property (st_valid && !f_ready);
	cov_cong_drop: cover property (take && metered && cong_s ##1 st_drop);
endmodule

// file: logic/tpm_defines.svh
// Register map, field positions, reset values and timing of the policer
`ifndef TPM_DEFINES_SVH
`define TPM_DEFINES_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define TPM_CLK_NS 25
`define TPM_CLK_HZ (1000000000 / `TPM_CLK_NS)

// ----------------------------------------
// Register word offsets (byte address bits 7:2)
// ----------------------------------------
`define TPM_OFF_CTRL 6'h00
`define TPM_OFF_CIR 6'h01
`define TPM_OFF_PIR 6'h02
`define TPM_OFF_CBS 6'h03
`define TPM_OFF_XBS 6'h04
`define TPM_OFF_MARK 6'h05
`define TPM_OFF_LVL1 6'h06
`define TPM_OFF_LVL2 6'h07

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TPM_CTRL_EN 0
`define TPM_CTRL_MODE 1
`define TPM_CTRL_GMARK 3
`define TPM_CTRL_YACT 4
`define TPM_CTRL_RMARK 6
`define TPM_MARK_G 0
`define TPM_MARK_Y 8
`define TPM_MARK_R 16

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TPM_RST_CTRL 32'h0000_0000
`define TPM_RST_CIR 32'h0000_0000
`define TPM_RST_PIR 32'h0000_0000
`define TPM_RST_CBS 32'h0000_0000
`define TPM_RST_XBS 32'h0000_0000
`define TPM_RST_MARK 32'h0000_0000

`endif

// file: logic/tpm_pkg.sv
// Types shared by the policer files
package tpm_pkg;
	typedef enum logic [1:0] {tpm_green, tpm_yellow, tpm_red} tpm_colour_t;
	typedef enum logic [1:0] {tpm_stb, tpm_srtcm, tpm_trtcm} tpm_mode_t;
	typedef enum logic [1:0] {tpm_ypass, tpm_ydrop, tpm_ymark} tpm_yact_t;
endpackage

// file: logic/tpm_fifo.sv
// Small synchronous FIFO with a registered output stage
`timescale 1ns/100ps
module tpm_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [CW-1:0] count;

	// ----------------------------------------
	// Handshake terms
	// ----------------------------------------
	wire push = in_valid && in_ready;
	wire load = (count != '0) && (!out_valid || out_ready);
	// Full once stored words plus the output register reach the depth
	assign in_ready = (count + CW'(out_valid)) < CW'(DEPTH);

	// Storage, written only on push
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wp] <= in_data;
		end
	end

	// Pointers, fill count, output register
	always_ff @(posedge clock) begin
		if (!resetn) begin
			wp <= '0;
			rp <= '0;
			count <= '0;
			out_valid <= 1'b0;
			out_data <= '0;
		end else begin
			if (push) begin
				wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
			end
			if (load) begin
				rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
				out_data <= mem[rp];
				out_valid <= 1'b1;
			end else if (out_ready) begin
				out_valid <= 1'b0;
			end
			count <= count + CW'(push) - CW'(load);
		end
	end
endmodule

// file: tb/tpm_sink.sv
// Downstream partner model: takes descriptors, can stall
`timescale 1ns/100ps
module tpm_sink (
	input wire logic clock,
	input wire logic resetn,
	input wire logic stall,
	input wire logic out_valid,
	output logic out_ready,
	input wire logic [15:0] out_len,
	input wire logic [5:0] out_dscp,
	input wire logic [1:0] out_colour
);
	logic [23:0] got [0:31];
	int n_got;
	// Record each accepted word; ready is the inverse of stall, a cycle late
	always_ff @(posedge clock) begin
		if (!resetn) begin
			out_ready <= 1'b0;
			n_got <= 0;
		end else begin
			out_ready <= ~stall;
			if (out_valid && out_ready) begin
				got[n_got[4:0]] <= {out_colour, out_dscp, out_len};
				n_got <= n_got + 1;
			end
		end
	end
endmodule

// file: tb/testbench.sv
// Self-checking bench for the policer meter
`timescale 1ns/100ps
module testbench;
	logic clock, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic in_valid, in_ready, in_member, congested, stall;
	logic out_valid, out_ready;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [15:0] in_len, out_len;
	logic [5:0] in_dscp, out_dscp;
	logic [1:0] out_colour;
	int bad_count, n_checks, rd_idx, k;

	tpm_meter i_tpm_meter (.clock(clock), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .in_valid(in_valid),
		.in_ready(in_ready), .in_len(in_len), .in_dscp(in_dscp), .in_member(in_member),
		.congested(congested), .out_valid(out_valid), .out_ready(out_ready),
		.out_len(out_len), .out_dscp(out_dscp), .out_colour(out_colour));
	tpm_sink u_sink (.clock(clock), .resetn(resetn), .stall(stall), .out_valid(out_valid),
		.out_ready(out_ready), .out_len(out_len), .out_dscp(out_dscp), .out_colour(out_colour));

	// ----------------------------------------
	// Clock, report and compare
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	task summarize;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task timeout;
		bad_count++;
		$display("[ERR] wait expected done seen timeout");
		summarize();
	endtask

	// ----------------------------------------
	// Bus and stream drivers
	// ----------------------------------------
	task wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
		int i;
		@(posedge clock);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= d;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (wb_ack_o !== 1'b1 && i < 50);
		if (wb_ack_o !== 1'b1) timeout();
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	task wr(input logic [7:0] adr, input logic [31:0] d);
		wb(1'b1, adr, d);
	endtask

	task rdchk(input string name, input logic [7:0] adr, input logic [31:0] exp);
		wb(1'b0, adr, 32'h0);
		check_val(name, exp, rd);
	endtask

	task send(input logic [15:0] len, input logic [5:0] dscp, input logic member);
		int i;
		@(posedge clock);
		in_valid <= 1'b1;
		in_len <= len;
		in_dscp <= dscp;
		in_member <= member;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (in_ready !== 1'b1 && i < 100);
		if (in_ready !== 1'b1) timeout();
		in_valid <= 1'b0;
		in_len <= ~len;
		in_dscp <= ~dscp;
	endtask

	task expect_pkt(input logic [15:0] len, input logic [5:0] dscp, input logic [1:0] col);
		int i;
		for (i = 0; i < 100 && u_sink.n_got <= rd_idx; i++) @(posedge clock);
		if (u_sink.n_got <= rd_idx) timeout();
		check_val("out_len", 32'(len), 32'(u_sink.got[rd_idx][15:0]));
		check_val("out_dscp", 32'(dscp), 32'(u_sink.got[rd_idx][21:16]));
		check_val("out_colour", 32'(col), 32'(u_sink.got[rd_idx][23:22]));
		rd_idx++;
	endtask

	task expect_none;
		repeat (12) @(posedge clock);
		check_val("dropped", rd_idx, u_sink.n_got);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task sc_regs;
		rdchk("ctrl", 8'h00, 32'h0);
		rdchk("mark", 8'h14, 32'h0);
		wr(8'h00, 32'hffff_fffe);
		rdchk("ctrl_bits", 8'h00, 32'h0000_007e);
		wr(8'h00, 32'h0);
		wr(8'h20, 32'h1234_5678);
		rdchk("unmapped", 8'h20, 32'h0);
		wr(8'h08, 32'h0000_0100);
		rdchk("pir", 8'h08, 32'h0000_0100);
		wr(8'h08, 32'h0);
	endtask

	task sc_simple;
		send(16'h0200, 6'h05, 1'b1);
		expect_pkt(16'h0200, 6'h05, 2'h0);
		wr(8'h0c, 32'h64);
		wr(8'h00, 32'h01);
		send(16'h3c, 6'h11, 1'b1);
		expect_pkt(16'h3c, 6'h11, 2'h0);
		rdchk("lvl1", 8'h18, 32'h28);
		send(16'h3c, 6'h11, 1'b1);
		expect_none();
		wr(8'h14, 32'h0015_0007);
		wr(8'h00, 32'h4f);
		send(16'h3c, 6'h11, 1'b1);
		expect_pkt(16'h3c, 6'h15, 2'h2);
		send(16'h1e, 6'h11, 1'b1);
		expect_pkt(16'h1e, 6'h07, 2'h0);
		send(16'h01f4, 6'h11, 1'b0);
		expect_pkt(16'h01f4, 6'h11, 2'h0);
	endtask

	task sc_two_rate;
		wr(8'h00, 32'h0);
		wr(8'h0c, 32'h32);
		wr(8'h10, 32'h64);
		wr(8'h14, 32'h0000_2a00);
		wr(8'h00, 32'h25);
		send(16'h28, 6'h09, 1'b1);
		expect_pkt(16'h28, 6'h09, 2'h0);
		send(16'h28, 6'h09, 1'b1);
		expect_pkt(16'h28, 6'h2a, 2'h1);
		rdchk("lvl2", 8'h1c, 32'h14);
		send(16'h1e, 6'h09, 1'b1);
		expect_none();
		@(posedge clock);
		congested <= 1'b1;
		repeat (4) @(posedge clock);
		send(16'h0f, 6'h09, 1'b1);
		expect_none();
		wr(8'h00, 32'h65);
		send(16'h1e, 6'h09, 1'b1);
		expect_none();
		congested <= 1'b0;
		wr(8'h08, 32'h0262_5a00);
		repeat (100) @(posedge clock);
		rdchk("lvl2_fill", 8'h1c, 32'h64);
		wr(8'h08, 32'h0);
	endtask

	task sc_single_rate;
		wr(8'h00, 32'h0);
		wr(8'h0c, 32'h14);
		wr(8'h10, 32'h32);
		wr(8'h00, 32'h03);
		send(16'h1e, 6'h0c, 1'b1);
		expect_pkt(16'h1e, 6'h0c, 2'h1);
		rdchk("lvl2", 8'h1c, 32'h14);
		send(16'h0a, 6'h0c, 1'b1);
		expect_pkt(16'h0a, 6'h0c, 2'h0);
		rdchk("lvl1", 8'h18, 32'h0a);
		wr(8'h04, 32'h0262_5a00);
		repeat (100) @(posedge clock);
		rdchk("lvl1_fill", 8'h18, 32'h14);
		rdchk("lvl2_fill", 8'h1c, 32'h32);
		wr(8'h00, 32'h13);
		send(16'h1e, 6'h0c, 1'b1);
		expect_none();
		wr(8'h04, 32'h0);
	endtask

	task sc_fifo;
		wr(8'h00, 32'h0);
		@(posedge clock);
		stall <= 1'b1;
		for (k = 1; k <= 9; k++) send(16'(k), 6'h01, 1'b1);
		repeat (6) @(posedge clock);
		check_val("in_ready_full", 32'h0, 32'(in_ready));
		stall <= 1'b0;
		send(16'ha, 6'h01, 1'b1);
		for (k = 1; k <= 10; k++) expect_pkt(16'(k), 6'h01, 2'h0);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		resetn = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h0;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0;
		in_valid = 1'b0;
		in_len = 16'h0;
		in_dscp = 6'h0;
		in_member = 1'b0;
		congested = 1'b0;
		stall = 1'b0;
		bad_count = 0;
		n_checks = 0;
		rd_idx = 0;
		repeat (10) @(posedge clock);
		resetn <= 1'b1;
		sc_regs();
		sc_simple();
		sc_two_rate();
		sc_single_rate();
		sc_fifo();
		summarize();
	end
endmodule
